// >>> rtl/vic_top.sv
// Vectored priority interrupt controller with an Avalon-MM register slave.
// Assumes all inputs are synchronous to ref_clk_i; one clock domain only.
`timescale 1ns/1ps
`default_nettype none
module vic_top
    import vic_pkg::*;
(
    input  wire logic        ref_clk_i,
    input  wire logic        rst_i,
    input  wire logic        ce_i,
    input  wire logic [8:0]  avs_address_i,
    input  wire logic        avs_read_i,
    input  wire logic        avs_write_i,
    input  wire logic [31:0] avs_writedata_i,
    input  wire logic [3:0]  avs_byteenable_i,
    output logic      [31:0] avs_readdata_o,
    output logic             avs_waitrequest_o,
    input  wire logic        fast_irq_input_i,
    input  wire logic        ext_irq_pin_a_i,
    input  wire logic        ext_irq_pin_b_i,
    input  wire logic        ext_irq_pin_c_i,
    input  wire logic [31:0] periph_irq_i,
    input  wire logic [6:0]  sys_irq_i,
    input  wire logic        conv_start_i,
    input  wire logic        conv_done_i,
    output logic             core_normal_irq_n_o,
    output logic             core_fast_irq_n_o,
    output logic             irq_o,
    output logic      [31:0] periph_clk_en_o
);
    logic [6:0]  mode_ff [NUM_SRC];
    logic [6:0]  nxt_mode [NUM_SRC];
    logic [31:0] vec_ff [NUM_SRC];
    logic [31:0] nxt_vec [NUM_SRC];
    logic [2:0]  stk_lvl_ff [STACK_DEPTH];
    logic [2:0]  nxt_stk_lvl [STACK_DEPTH];
    logic [4:0]  stk_src_ff [STACK_DEPTH];
    logic [4:0]  nxt_stk_src [STACK_DEPTH];
    logic [3:0]  depth_ff;
    logic [3:0]  nxt_depth;
    logic [31:0] en_ff;
    logic [31:0] nxt_en;
    logic [31:0] ffr_ff;
    logic [31:0] nxt_ffr;
    logic        protect_ff;
    logic        nxt_protect;
    logic [31:0] spu_ff;
    logic [31:0] nxt_spu;
    logic [2:0]  evt_ff;
    logic [2:0]  nxt_evt;
    logic [2:0]  evt_mask_ff;
    logic [2:0]  nxt_evt_mask;
    logic        irq_ff;
    logic        nxt_irq;
    logic [31:0] clk_ff;
    logic [31:0] nxt_clk;
    logic        sleep_ff;
    logic        nxt_sleep;
    logic        wait_ff;
    logic        nxt_wait;
    logic [31:0] rdata_ff;
    logic [31:0] nxt_rdata;
    logic        core_normal_irq_n_ff;
    logic        core_fast_irq_n_ff;
    logic [31:0] raw_src;
    logic [31:0] pend;
    logic [31:0] edge_clr;
    logic [31:0] wmask;
    logic [31:0] wd;
    logic        rd_do;
    logic        wr_do;
    logic        ack_do;
    logic        win_valid;
    logic [4:0]  win_src;
    logic [2:0]  win_prio;
    logic [31:0] win_vec;
    logic [2:0]  top;
    logic [2:0]  cur_lvl;
    logic [4:0]  cur_src;
    logic        irq_req;
    logic        fast_req;
    logic [4:0]  ridx;

    // Source map: fast pin on 0, system OR on 1, pins a-c on 29-31.
    always_comb begin
        raw_src            = periph_irq_i & PERIPH_SRC_MASK;
        raw_src[SRC_FAST]  = fast_irq_input_i;
        raw_src[SRC_SYS]   = |sys_irq_i;
        raw_src[SRC_EXT_A] = ext_irq_pin_a_i;
        raw_src[SRC_EXT_B] = ext_irq_pin_b_i;
        raw_src[SRC_EXT_C] = ext_irq_pin_c_i;
    end

    // One cell per source; only the four external ones honour the polarity bit.
    genvar g;
    generate
        for (g = 0; g < NUM_SRC; g++) begin : g_src
            vic_src_cond #(
                .EXT_POL ((g == SRC_FAST) || (g >= SRC_EXT_A))
            ) u_cond (
                .ref_clk_i (ref_clk_i),
                .rst_i     (rst_i),
                .ce_i      (ce_i),
                .raw_i     (raw_src[g]),
                .trig_i    (mode_ff[g][TRIG_HI:TRIG_LO]),
                .clr_i     (edge_clr[g]),
                .pend_o    (pend[g])
            );
        end
    endgenerate

    // Bus timing: a request is answered one cycle after it is first seen.
    always_comb begin
        rd_do = ce_i && avs_read_i && wait_ff;
        wr_do = ce_i && avs_write_i && !wait_ff;
        nxt_wait = !((avs_read_i || avs_write_i) && wait_ff);
        wmask = {{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}},
                 {8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
        wd = avs_writedata_i & wmask;
        ridx = avs_address_i[6:2];
    end

    // Ascending scan with a strict compare keeps the lowest number on ties.
    always_comb begin
        win_valid = 1'b0;
        win_src   = 5'h00;
        win_prio  = 3'h0;
        for (int n = 1; n < NUM_SRC; n++) begin
            if (pend[n] && en_ff[n] && !ffr_ff[n]
                && (!win_valid || mode_ff[n][PRIO_HI:0] > win_prio)) begin
                win_valid = 1'b1;
                win_src   = 5'(n);
                win_prio  = mode_ff[n][PRIO_HI:0];
            end
        end
        win_vec = vec_ff[win_src];
        top     = 3'(depth_ff - 4'h1);
        cur_lvl = stk_lvl_ff[top];
        cur_src = (depth_ff == 4'h0) ? 5'h00 : stk_src_ff[top];
        // A full stack blocks further nesting rather than losing a level.
        irq_req = win_valid && ((depth_ff == 4'h0)
                  || (win_prio > cur_lvl && depth_ff < 4'(STACK_DEPTH)));
        fast_req = |(pend & en_ff & (ffr_ff | 32'h0000_0001));
        // Under protect, reads never acknowledge; software writes instead.
        ack_do = (rd_do && avs_address_i == OFS_IVR && !protect_ff)
                 || (wr_do && avs_address_i == OFS_IVR && protect_ff);
    end

    // Register read mux; the vector read picks the winning source's vector.
    always_comb begin
        nxt_rdata = rdata_ff;
        if (rd_do) begin
            if (avs_address_i < OFS_VEC) begin
                nxt_rdata = {25'h0000000, mode_ff[ridx]};
            end else if (avs_address_i < OFS_IVR) begin
                nxt_rdata = vec_ff[ridx];
            end else begin
                case (avs_address_i)
                    OFS_IVR:      nxt_rdata = irq_req ? win_vec : spu_ff;
                    OFS_FVR:      nxt_rdata = fast_req ? vec_ff[SRC_FAST] : spu_ff;
                    OFS_ISR:      nxt_rdata = {27'h0000000, cur_src};
                    OFS_IPR:      nxt_rdata = pend;
                    OFS_IMR:      nxt_rdata = en_ff;
                    OFS_FFSR:     nxt_rdata = ffr_ff;
                    OFS_PROT:     nxt_rdata = {31'h00000000, protect_ff};
                    OFS_SPU:      nxt_rdata = spu_ff;
                    OFS_CORE:     nxt_rdata = {30'h00000000, !core_fast_irq_n_ff, !core_normal_irq_n_ff};
                    OFS_EVT_STAT: nxt_rdata = {29'h00000000, evt_ff};
                    OFS_EVT_MASK: nxt_rdata = {29'h00000000, evt_mask_ff};
                    OFS_PCSR:     nxt_rdata = clk_ff;
                    OFS_CONV:     nxt_rdata = {31'h00000000, sleep_ff};
                    default:      nxt_rdata = 32'h0000_0000;
                endcase
            end
        end
    end

    // Configuration, mask, forcing and the nesting stack.
    always_comb begin
        nxt_mode    = mode_ff;
        nxt_vec     = vec_ff;
        nxt_stk_lvl = stk_lvl_ff;
        nxt_stk_src = stk_src_ff;
        nxt_depth   = depth_ff;
        nxt_en      = en_ff;
        nxt_ffr     = ffr_ff;
        nxt_protect = protect_ff;
        nxt_spu     = spu_ff;
        edge_clr    = 32'h0000_0000;
        if (wr_do) begin
            if (avs_address_i < OFS_VEC) begin
                nxt_mode[ridx] = 7'((mode_ff[ridx] & ~wmask[6:0]) | wd[6:0]);
            end else if (avs_address_i < OFS_IVR) begin
                nxt_vec[ridx] = (vec_ff[ridx] & ~wmask) | wd;
            end else begin
                case (avs_address_i)
                    OFS_IECR:  nxt_en = en_ff | wd;
                    OFS_IDCR:  nxt_en = en_ff & ~wd;
                    OFS_ICCR:  edge_clr = wd;
                    OFS_EOICR: nxt_depth = (depth_ff == 4'h0) ? depth_ff : depth_ff - 4'h1;
                    OFS_FFER:  nxt_ffr = ffr_ff | (wd & 32'hFFFF_FFFE);
                    OFS_FFDR:  nxt_ffr = ffr_ff & ~wd;
                    OFS_PROT:  nxt_protect = (protect_ff & ~wmask[0]) | wd[0];
                    OFS_SPU:   nxt_spu = (spu_ff & ~wmask) | wd;
                    default:   nxt_depth = depth_ff;
                endcase
            end
        end
        // Acknowledge: push the level, clear the winner's edge latch.
        if (ack_do && irq_req) begin
            nxt_stk_lvl[depth_ff[2:0]] = win_prio;
            nxt_stk_src[depth_ff[2:0]] = win_src;
            nxt_depth = depth_ff + 4'h1;
            edge_clr[win_src] = 1'b1;
        end
        if (rd_do && avs_address_i == OFS_FVR && !protect_ff) begin
            edge_clr[SRC_FAST] = 1'b1;
        end
    end

    // Event flags: set wins over the write-one-to-clear in the same cycle.
    always_comb begin
        logic [2:0] w1c;
        logic [2:0] hit;
        w1c = (wr_do && avs_address_i == OFS_EVT_STAT) ? wd[2:0] : 3'h0;
        hit = 3'h0;
        hit[EVT_NORMAL] = irq_req && core_normal_irq_n_ff;
        hit[EVT_FAST]   = fast_req && core_fast_irq_n_ff;
        hit[EVT_SPUR]   = ack_do && !irq_req;
        nxt_evt = (evt_ff & ~w1c) | hit;
        nxt_evt_mask = evt_mask_ff;
        if (wr_do && avs_address_i == OFS_EVT_MASK) begin
            nxt_evt_mask = (evt_mask_ff & ~wmask[2:0]) | wd[2:0];
        end
        nxt_irq = |(nxt_evt & nxt_evt_mask);
    end

    // Peripheral clock gates; fixed bits never move whatever is written.
    always_comb begin
        nxt_clk   = clk_ff;
        nxt_sleep = sleep_ff;
        if (wr_do && avs_address_i == OFS_PCER) begin
            nxt_clk = clk_ff | (wd & CLK_CTRL_MASK);
        end
        if (wr_do && avs_address_i == OFS_PCDR) begin
            nxt_clk = clk_ff & ~(wd & CLK_CTRL_MASK);
        end
        if (wr_do && avs_address_i == OFS_CONV) begin
            nxt_sleep = (sleep_ff & ~wmask[0]) | wd[0];
        end
        // Start wins over a stop in the same cycle so a new conversion has a clock.
        if (conv_start_i) begin
            nxt_clk[SRC_CONV] = 1'b1;
        end else if (conv_done_i && sleep_ff) begin
            nxt_clk[SRC_CONV] = 1'b0;
        end
    end

    // All state registers; everything freezes while ce_i is low.
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            for (int n = 0; n < NUM_SRC; n++) begin
                mode_ff[n] <= 7'h00;
                vec_ff[n]  <= 32'h0000_0000;
            end
            for (int n = 0; n < STACK_DEPTH; n++) begin
                stk_lvl_ff[n] <= 3'h0;
                stk_src_ff[n] <= 5'h00;
            end
            depth_ff    <= 4'h0;
            en_ff       <= 32'h0000_0000;
            ffr_ff      <= 32'h0000_0000;
            protect_ff  <= 1'b0;
            spu_ff      <= 32'h0000_0000;
            evt_ff      <= 3'h0;
            evt_mask_ff <= 3'h0;
            irq_ff      <= 1'b0;
            clk_ff      <= CLK_RESET;
            sleep_ff    <= 1'b0;
            wait_ff     <= 1'b1;
            rdata_ff    <= 32'h0000_0000;
            core_normal_irq_n_ff     <= 1'b1;
            core_fast_irq_n_ff     <= 1'b1;
        end else if (ce_i) begin
            mode_ff     <= nxt_mode;
            vec_ff      <= nxt_vec;
            stk_lvl_ff  <= nxt_stk_lvl;
            stk_src_ff  <= nxt_stk_src;
            depth_ff    <= nxt_depth;
            en_ff       <= nxt_en;
            ffr_ff      <= nxt_ffr;
            protect_ff  <= nxt_protect;
            spu_ff      <= nxt_spu;
            evt_ff      <= nxt_evt;
            evt_mask_ff <= nxt_evt_mask;
            irq_ff      <= nxt_irq;
            clk_ff      <= nxt_clk;
            sleep_ff    <= nxt_sleep;
            wait_ff     <= nxt_wait;
            rdata_ff    <= nxt_rdata;
            core_normal_irq_n_ff     <= !irq_req;
            core_fast_irq_n_ff     <= !fast_req;
        end
    end

    // Outputs come straight from flip-flops.
    assign avs_readdata_o      = rdata_ff;
    assign avs_waitrequest_o   = wait_ff;
    assign core_normal_irq_n_o = core_normal_irq_n_ff;
    assign core_fast_irq_n_o   = core_fast_irq_n_ff;
    assign irq_o               = irq_ff;
    assign periph_clk_en_o     = clk_ff;

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);

    sequence s_ivr_ack;
        ack_do && irq_req && depth_ff != 4'h0;
    endsequence

    chk_normal_line: assert property (ce_i && irq_req |=> !core_normal_irq_n_o)
        else $error("normal request not driven low");
    chk_fast_force: assert property (ce_i && fast_req |=> !core_fast_irq_n_o)
        else $error("fast request not driven low");
    chk_vec_read: assert property (rd_do && avs_address_i == OFS_IVR && irq_req
        |=> avs_readdata_o == $past(win_vec) && !avs_waitrequest_o)
        else $error("vector read returned wrong vector");
    chk_protect_hold: assert property (rd_do && avs_address_i == OFS_IVR && protect_ff
        |=> $stable(depth_ff))
        else $error("protected read changed the nesting depth");
    chk_nest_push: assert property (s_ivr_ack |=> depth_ff == $past(depth_ff) + 4'h1)
        else $error("nested acknowledge did not push");
    chk_sys_or: assert property (ce_i && (|sys_irq_i)
        && mode_ff[SRC_SYS][TRIG_HI:TRIG_LO] == TRIG_HIGH |=> pend[SRC_SYS])
        else $error("system source not pending");
    chk_pin_c_low: assert property (ce_i && !ext_irq_pin_c_i
        && mode_ff[SRC_EXT_C][TRIG_HI:TRIG_LO] == TRIG_LOW |=> pend[SRC_EXT_C])
        else $error("pin c low level not pending");
    chk_clk_fixed: assert property ((periph_clk_en_o & CLK_FIXED_MASK) == CLK_RESET)
        else $error("fixed clock bit moved");
    chk_conv_clk: assert property (ce_i && conv_start_i |=> periph_clk_en_o[SRC_CONV])
        else $error("converter clock not started");
    chk_edge_latch: assert property (ce_i && pend[2] && mode_ff[2][TRIG_LO]
        && !edge_clr[2] |=> pend[2])
        else $error("edge pending lost");
    chk_reserved_id: assert property (pend[16:15] == 2'h0)
        else $error("reserved identifier pending");
    chk_bus_answer: assert property (wait_ff && avs_read_i && ce_i |=> !avs_waitrequest_o)
        else $error("read not answered after one wait cycle");
endmodule : vic_top
`default_nettype wire

// >>> rtl/vic_pkg.sv
// Constants shared by the vectored interrupt controller and its source cells.
// Assumes one 125 MHz clock domain and a synchronous, active-high reset.
// What this block does
// - Internal sources are programmable edge or level triggered.
// - External pins choose rising, falling, high level or low level.
// - Three general external pins plus one fast pin are accepted.
// - Eight-level resolver arbitrates sources 1 to 31 onto the normal line.
// - Strictly higher priority may interrupt a serviced lower level, nesting.
// - One vector per source; vector read returns the winning source's vector.
// - Protect mode stops reads from changing interrupt state.
// - Fast forcing reroutes chosen normal sources to the fast line.
// - Source 1 is the OR of the seven system peripheral interrupts.
// - Pins a, b, c are sources 29, 30, 31; fast pin is source 0.
// - Identifier selects source and clock bit; 15 and 16 unused.
// - Clock set or clear on ids 0, 1, 5, 20, 29-31 does nothing.
// - Converter clock starts on conversion; in sleep stops after each one.
// - System peripheral clocks never stop; id 1 is only an interrupt source.
// - External pin identifiers have no clock gating.
// - Two active-low request outputs: normal line and fast line.
// - Every source is maskable and carries its own vector.
package vic_pkg;
    localparam int          NUM_SRC        = 32;
    localparam int          STACK_DEPTH    = 8;
    localparam int          PRIO_HI        = 2;
    localparam int          TRIG_LO        = 5;
    localparam int          TRIG_HI        = 6;
    localparam int          TRIG_EDGE_BIT  = 0;
    localparam int          TRIG_LOW_BIT   = 1;
    localparam logic [1:0]  TRIG_HIGH      = 2'h0;
    localparam logic [1:0]  TRIG_LOW       = 2'h2;
    localparam int          SRC_FAST       = 0;
    localparam int          SRC_SYS        = 1;
    localparam int          SRC_EXT_A      = 29;
    localparam int          SRC_EXT_B      = 30;
    localparam int          SRC_EXT_C      = 31;
    localparam int          SRC_CONV       = 5;
    localparam logic [31:0] PERIPH_SRC_MASK = 32'h1FFE_7FFC;
    localparam logic [31:0] CLK_CTRL_MASK  = 32'h1FEE_7FDC;
    localparam logic [31:0] CLK_FIXED_MASK = 32'hE011_8003;
    localparam logic [31:0] CLK_RESET      = 32'h0000_0002;
    localparam logic [8:0]  OFS_MODE       = 9'h000;
    localparam logic [8:0]  OFS_VEC        = 9'h080;
    localparam logic [8:0]  OFS_IVR        = 9'h100;
    localparam logic [8:0]  OFS_FVR        = 9'h104;
    localparam logic [8:0]  OFS_ISR        = 9'h108;
    localparam logic [8:0]  OFS_IPR        = 9'h10C;
    localparam logic [8:0]  OFS_IMR        = 9'h110;
    localparam logic [8:0]  OFS_IECR       = 9'h114;
    localparam logic [8:0]  OFS_IDCR       = 9'h118;
    localparam logic [8:0]  OFS_ICCR       = 9'h11C;
    localparam logic [8:0]  OFS_EOICR      = 9'h120;
    localparam logic [8:0]  OFS_FFER       = 9'h124;
    localparam logic [8:0]  OFS_FFDR       = 9'h128;
    localparam logic [8:0]  OFS_FFSR       = 9'h12C;
    localparam logic [8:0]  OFS_PROT       = 9'h130;
    localparam logic [8:0]  OFS_SPU        = 9'h134;
    localparam logic [8:0]  OFS_CORE       = 9'h138;
    localparam logic [8:0]  OFS_EVT_STAT   = 9'h13C;
    localparam logic [8:0]  OFS_EVT_MASK   = 9'h140;
    localparam logic [8:0]  OFS_PCER       = 9'h144;
    localparam logic [8:0]  OFS_PCDR       = 9'h148;
    localparam logic [8:0]  OFS_PCSR       = 9'h14C;
    localparam logic [8:0]  OFS_CONV       = 9'h150;
    localparam int          EVT_NORMAL     = 0;
    localparam int          EVT_FAST       = 1;
    localparam int          EVT_SPUR       = 2;
endpackage : vic_pkg

// >>> rtl/vic_src_cond.sv
// One interrupt source cell: trigger selection and the pending flag.
// Assumes the raw request is synchronous to ref_clk_i.
`timescale 1ns/1ps
`default_nettype none
module vic_src_cond
    import vic_pkg::*;
#(
    parameter bit EXT_POL = 1'b0
) (
    input  wire logic       ref_clk_i,
    input  wire logic       rst_i,
    input  wire logic       ce_i,
    input  wire logic       raw_i,
    input  wire logic [1:0] trig_i,
    input  wire logic       clr_i,
    output logic            pend_o
);
    logic prev_ff;
    logic pend_ff;
    logic nxt_prev;
    logic nxt_pend;
    logic act_lvl;

    // Internal sources ignore the polarity bit, so they offer only edge or level.
    always_comb begin
        act_lvl  = (EXT_POL && trig_i[TRIG_LOW_BIT]) ? !raw_i : raw_i;
        nxt_prev = act_lvl;
        if (trig_i[TRIG_EDGE_BIT]) begin
            // A new edge in the clearing cycle wins, so no edge is lost.
            nxt_pend = (pend_ff && !clr_i) || (act_lvl && !prev_ff);
        end else begin
            nxt_pend = act_lvl;
        end
    end

    // State only moves while the clock enable is high.
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            prev_ff <= 1'b0;
            pend_ff <= 1'b0;
        end else if (ce_i) begin
            prev_ff <= nxt_prev;
            pend_ff <= nxt_pend;
        end
    end

    assign pend_o = pend_ff;
endmodule : vic_src_cond
`default_nettype wire

// >>> bench/vic_periph_model.sv
// Peripheral side model: turns the bench's request pattern into peripheral lines.
// Assumes the controller's clock; slow_i adds two cycles of latency to every line.
`timescale 1ns/1ps
`default_nettype none
module vic_periph_model (
    input  wire logic        ref_clk_i,
    input  wire logic        rst_i,
    input  wire logic        slow_i,
    input  wire logic [31:0] req_i,
    input  wire logic [6:0]  sys_i,
    output logic      [31:0] periph_irq_o,
    output logic      [6:0]  sys_irq_o
);
    logic [38:0] dly_ff [3];
    // Requests pass a short pipe, so a line can follow promptly or slowly.
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            dly_ff <= '{default: 39'h0};
        end else begin
            dly_ff[0] <= {sys_i, req_i};
            dly_ff[1] <= dly_ff[0];
            dly_ff[2] <= dly_ff[1];
        end
    end
    // Identifiers 15 and 16 have nothing behind them, so those lines stay low.
    assign periph_irq_o = (slow_i ? dly_ff[2][31:0] : dly_ff[0][31:0]) & 32'hFFFE_7FFF;
    assign sys_irq_o    = slow_i ? dly_ff[2][38:32] : dly_ff[0][38:32];
endmodule : vic_periph_model
`default_nettype wire

// >>> bench/testbench.sv
// Self-checking bench for the interrupt controller: register rows, then awkward cases.
// Assumes one 125 MHz clock; peripheral lines come from vic_periph_model.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import vic_pkg::*;
    typedef struct {logic [8:0] wa; logic [31:0] wd; logic [8:0] ra; logic [31:0] ex;} vic_row_type;
    logic        ref_clk_i, rst_i, rd, wr, fin, pa, pb, cs, slow, nrm_n, fst_n, irq, wq;
    logic        ce, pc, cd;
    logic [8:0]  adr;
    logic [31:0] wd, rdat, req, per, clk_en, rv;
    logic [6:0]  sys, sysl;
    int          errors, n_compared, cyc;
    vic_row_type rows [6] = '{
        '{OFS_IECR, 32'h0000_0004, OFS_IMR, 32'h0000_0004},
        '{OFS_IDCR, 32'h0000_0004, OFS_IMR, 32'h0000_0000},
        '{9'h0F4, 32'hCAFE_0029, 9'h0F4, 32'hCAFE_0029},
        '{OFS_PCER, 32'hFFFF_FFFF, OFS_PCSR, 32'h1FEE_7FDE},
        '{OFS_PCDR, 32'hFFFF_FFFF, OFS_PCSR, 32'h0000_0002},
        '{9'h1FC, 32'hFFFF_FFFF, 9'h1FC, 32'h0000_0000}};
    vic_top i_vic_top (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .ce_i(ce), .avs_address_i(adr),
        .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(4'hF),
        .avs_readdata_o(rdat), .avs_waitrequest_o(wq), .fast_irq_input_i(fin),
        .ext_irq_pin_a_i(pa), .ext_irq_pin_b_i(pb), .ext_irq_pin_c_i(pc), .periph_irq_i(per),
        .sys_irq_i(sysl), .conv_start_i(cs), .conv_done_i(cd), .core_normal_irq_n_o(nrm_n),
        .core_fast_irq_n_o(fst_n), .irq_o(irq), .periph_clk_en_o(clk_en));
    vic_periph_model i_vic_periph_model (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .slow_i(slow),
        .req_i(req), .sys_i(sys), .periph_irq_o(per), .sys_irq_o(sysl));
    // Free-running clock at 8 ns.
    initial begin
        ref_clk_i = 1'b0;
        forever #4 ref_clk_i = ~ref_clk_i;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("BAD at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic report_and_stop();
        $display("Compared %0d, errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : report_and_stop
    // One Avalon access; the request holds until waitrequest is seen low at an edge.
    task automatic bus(input logic w, input logic [8:0] a, input logic [31:0] d);
        @(posedge ref_clk_i);
        adr <= a;
        wd  <= d;
        rd  <= ~w;
        wr  <= w;
        do @(posedge ref_clk_i); while (wq !== 1'b0);
        rv = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask : bus
    // Waits a bounded time for a core line to reach a level, then compares it.
    task automatic wait_line(input logic fast, input logic lvl);
        for (int i = 0; i < 12 && (fast ? fst_n : nrm_n) !== lvl; i++) @(posedge ref_clk_i);
        check({31'h0, fast ? fst_n : nrm_n}, {31'h0, lvl});
    endtask : wait_line
    // A hang is cut short here and counted as a mismatch.
    always @(posedge ref_clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            errors++;
            report_and_stop();
        end
    end
    initial begin
        {rst_i, rd, wr, fin, pa, pb, cs, slow, ce, pc, cd} = 11'h404;
        {adr, wd, req, sys, errors, n_compared, cyc} = '0;
        repeat (2) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        @(negedge ref_clk_i);
        check({wq, nrm_n, fst_n, irq}, 32'hE);
        check(clk_en, CLK_RESET);
        // Ordinary register cases: write one place, read back there or at its matching mask or status register.
        foreach (rows[i]) begin
            bus(1'b1, rows[i].wa, rows[i].wd);
            bus(1'b0, rows[i].ra, 32'h0);
            check(rv, rows[i].ex);
            if (rows[i].ra == OFS_PCSR) check(clk_en, rows[i].ex);
        end
        // Nesting: rising pin a at priority 3, then pin b at priority 5.
        bus(1'b1, 9'h074, 32'h0000_0023);
        bus(1'b1, 9'h078, 32'h0000_0025);
        bus(1'b1, 9'h0F8, 32'h0000_0030);
        bus(1'b1, OFS_EVT_MASK, 32'h0000_0001);
        bus(1'b1, OFS_IECR, 32'h6000_0000);
        pa <= 1'b1;
        wait_line(1'b0, 1'b0);
        check({31'h0, irq}, 32'h1);
        bus(1'b0, OFS_IVR, 32'h0);
        check(rv, 32'hCAFE_0029);
        bus(1'b0, OFS_ISR, 32'h0);
        check(rv, SRC_EXT_A);
        wait_line(1'b0, 1'b1);
        pb <= 1'b1;
        wait_line(1'b0, 1'b0);
        bus(1'b0, OFS_IVR, 32'h0);
        check(rv, 32'h0000_0030);
        bus(1'b1, OFS_EOICR, 32'h0);
        bus(1'b1, OFS_EOICR, 32'h0);
        bus(1'b1, OFS_EVT_STAT, 32'h0000_0007);
        // The clear lands on the edge the task returns at, so look one edge later.
        @(posedge ref_clk_i);
        check({31'h0, irq}, 32'h0);
        // Pin c at low level under protect: a read leaves state alone, a write acknowledges.
        bus(1'b1, 9'h0FC, 32'h0000_0031);
        bus(1'b1, OFS_PROT, 32'h0000_0001);
        bus(1'b1, 9'h07C, 32'h0000_0040);
        bus(1'b1, OFS_IECR, 32'h8000_0000);
        wait_line(1'b0, 1'b0);
        bus(1'b0, OFS_IVR, 32'h0);
        check(rv, 32'h0000_0031);
        bus(1'b0, OFS_ISR, 32'h0);
        check(rv, 32'h0);
        bus(1'b1, OFS_IVR, 32'h0);
        bus(1'b0, OFS_ISR, 32'h0);
        check(rv, SRC_EXT_C);
        pc <= 1'b1;
        bus(1'b1, OFS_EOICR, 32'h0);
        bus(1'b1, OFS_PROT, 32'h0);
        // Equal priority: edge source 2 beats level source 4, and source 4 does not nest over it.
        bus(1'b1, 9'h008, 32'h0000_0022);
        bus(1'b1, 9'h010, 32'h0000_0002);
        bus(1'b1, 9'h088, 32'h0000_0022);
        bus(1'b1, 9'h090, 32'h0000_0044);
        bus(1'b1, OFS_IECR, 32'h0000_0014);
        req <= 32'h0000_0014;
        wait_line(1'b0, 1'b0);
        bus(1'b0, OFS_IVR, 32'h0);
        check(rv, 32'h0000_0022);
        wait_line(1'b0, 1'b1);
        bus(1'b1, OFS_EOICR, 32'h0);
        wait_line(1'b0, 1'b0);
        bus(1'b0, OFS_IVR, 32'h0);
        check(rv, 32'h0000_0044);
        req <= 32'h0;
        bus(1'b1, OFS_EOICR, 32'h0);
        // Forced source 3, slow peripheral: fast line only, level follows the request.
        slow <= 1'b1;
        bus(1'b1, OFS_FFER, 32'h0000_0008);
        bus(1'b1, OFS_IECR, 32'h0000_000B);
        req <= 32'h0000_0008;
        wait_line(1'b1, 1'b0);
        check({31'h0, nrm_n}, 32'h1);
        req <= 32'h0;
        wait_line(1'b1, 1'b1);
        // System source and the fast pin.
        sys <= 7'h40;
        wait_line(1'b0, 1'b0);
        sys <= 7'h0;
        wait_line(1'b0, 1'b1);
        fin <= 1'b1;
        wait_line(1'b1, 1'b0);
        fin <= 1'b0;
        // A conversion start turns on the converter clock by itself.
        cs <= 1'b1;
        @(posedge ref_clk_i);
        cs <= 1'b0;
        repeat (3) @(posedge ref_clk_i);
        check({31'h0, clk_en[SRC_CONV]}, 32'h1);
        // In sleep the converter clock stops once the conversion is done.
        bus(1'b1, OFS_CONV, 32'h0000_0001);
        cd <= 1'b1;
        @(posedge ref_clk_i);
        cd <= 1'b0;
        repeat (2) @(posedge ref_clk_i);
        check({31'h0, clk_en[SRC_CONV]}, 32'h0);
        // A low clock enable freezes the sources; the request shows once it returns.
        ce  <= 1'b0;
        sys <= 7'h01;
        repeat (6) @(posedge ref_clk_i);
        check({31'h0, nrm_n}, 32'h1);
        ce <= 1'b1;
        wait_line(1'b0, 1'b0);
        report_and_stop();
    end
endmodule : testbench
`default_nettype wire
